/* File: bench/bllfe_host.sv */
// Programming host model driving frames onto the byte link
`timescale 1ns/100ps
module bllfe_host (
  input  wire logic       clk,
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_end
);
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'hA5;
    rx_end   = 1'b0;
  end

  // ----------------------------------------------------------
  // Byte and frame transfer
  // ----------------------------------------------------------
  task automatic put(input logic [7:0] b, input logic last);
    int k;
    repeat (1 + $urandom_range(2)) @(posedge clk);
    #1;
    rx_valid = 1'b1;
    rx_data  = b;
    rx_end   = last;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (!rx_ready && k < 2000);
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_end   = 1'b0;
    rx_data  = ~b;
  endtask

  // Mode 0 good checksum, 1 corrupt checksum, 2 frame cut short
  task automatic send(input logic [7:0] f[$], input int mode);
    logic [8:0] s;
    s = 9'h0;
    foreach (f[i]) begin
      put(f[i], 1'b0);
      s = s + {1'b0, f[i]};
      if (s[8]) s = s - 9'h0FF;
    end
    if (mode != 2) put(~s[7:0] ^ {7'h0, mode == 1}, 1'b1);
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule

/* File: bench/bllfe_top_assertions.sv */
// Port checker of the boot loader link front end
`timescale 1ns/100ps
module bllfe_top_assertions #(
  parameter int TICK_CYC = 20
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] nac_cfg,
  input wire logic       link_locked,
  input wire logic       nac_expired,
  input wire logic       frame_timeout,
  input wire logic       chk_req,
  input wire logic       chk_valid,
  input wire logic       chk_bounds_ok,
  input wire logic       chk_prot_ok,
  input wire logic       chk_mode_ok,
  input wire logic       run_done,
  input wire logic       run_ok,
  input wire logic       run_is_read,
  input wire logic       run_is_jump,
  input wire logic       run_req,
  input wire logic       resp_req,
  input wire logic       resp_is_data,
  input wire logic       resp_err
);
  logic [31:0] age_q;
  logic [31:0] age_d;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------
  // Cycles since reset release
  // ----------------------------------------------------------
  always_comb begin
    age_d = age_q;
    if (age_q != 32'hFFFFFFFF) age_d = age_q + 32'h1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) age_q <= 32'h0;
    else age_q <= age_d;
  end

  sequence s_pass;
    chk_valid && chk_bounds_ok && chk_prot_ok && chk_mode_ok;
  endsequence
  sequence s_fail;
    chk_valid && !(chk_bounds_ok && chk_prot_ok && chk_mode_ok);
  endsequence
  sequence s_jump_ok;
    run_done && run_ok && run_is_jump;
  endsequence

  AST_LOCK_QUIET: assert property (
    link_locked |-> !chk_req && !resp_req
  ) else $error("activity while link locked");
  AST_STAY_OPEN: assert property (
    !link_locked |=> !link_locked
  ) else $error("link relocked without reset");
  AST_NAC_STOPS: assert property (
    !link_locked |-> !nac_expired
  ) else $error("no-activity expiry after unlock");
  AST_NAC_HOLD: assert property (
    nac_expired |=> nac_expired && link_locked
  ) else $error("no-activity expiry not sticky");
  AST_NAC_TIME: assert property (
    $rose(nac_expired) |-> age_q + 32'h2 >= nac_cfg * TICK_CYC &&
      age_q <= (nac_cfg + 1) * TICK_CYC + 4
  ) else $error("no-activity expiry at wrong time");
  AST_PASS_RUN: assert property (
    s_pass |=> run_req
  ) else $error("passed command not run");
  AST_FAIL_ERR: assert property (
    s_fail |-> ##[1:4] resp_req && resp_err && !resp_is_data
  ) else $error("failed check without error status");
  AST_RUN_FAIL: assert property (
    run_done && !run_ok |=> resp_req && resp_err && !resp_is_data
  ) else $error("failed run without error status");
  AST_RUN_GOOD: assert property (
    run_done && run_ok && !run_is_jump |=> resp_req && !resp_err &&
      resp_is_data == $past(run_is_read)
  ) else $error("wrong response after good run");
  AST_JUMP_QUIET: assert property (
    s_jump_ok |=> !resp_req [*3]
  ) else $error("reply after good code execution");
  AST_TMO_OPEN: assert property (
    frame_timeout |-> !link_locked
  ) else $error("frame timeout while locked");
endmodule

bind bllfe_top bllfe_top_assertions #(.TICK_CYC(TICK_CYC)) i_chk (
  .clk(clk), .rst(rst), .nac_cfg(nac_cfg), .link_locked(link_locked),
  .nac_expired(nac_expired), .frame_timeout(frame_timeout),
  .chk_req(chk_req), .chk_valid(chk_valid), .chk_bounds_ok(chk_bounds_ok),
  .chk_prot_ok(chk_prot_ok), .chk_mode_ok(chk_mode_ok),
  .run_done(run_done), .run_ok(run_ok), .run_is_read(run_is_read),
  .run_is_jump(run_is_jump), .run_req(run_req), .resp_req(resp_req),
  .resp_is_data(resp_is_data), .resp_err(resp_err));

/* File: bench/test_boot_loader_link_front_end.sv */
// Self-checking testbench of the boot loader link front end
`timescale 1ns/100ps
module test_boot_loader_link_front_end;
  localparam int TICK_T = 20;
  typedef struct {
    logic [7:0] len;
    logic [7:0] typ;
    logic       cok;
    logic       rok;
    logic       rd;
    logic       jmp;
  } bllfe_note_t;
  logic        clk, rst, rx_valid, rx_end, rx_ready, link_locked;
  logic        nac_expired, frame_timeout, chk_req, chk_valid, run_req;
  logic        chk_bounds_ok, chk_prot_ok, chk_mode_ok, run_done, run_ok;
  logic        run_is_read, run_is_jump, resp_req, resp_is_data, resp_err;
  logic        resp_done;
  logic [7:0]  rx_data, nac_cfg, ift_cfg, node_addr, cmd_len, rd_addr;
  logic [7:0]  rd_data;
  int          error_cnt, total_checks;
  bllfe_note_t notes[$];

  bllfe_top #(.TICK_CYC(TICK_T)) i_bllfe_top (
    .clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end), .rx_ready(rx_ready), .nac_cfg(nac_cfg),
    .ift_cfg(ift_cfg), .node_addr(node_addr), .link_locked(link_locked),
    .nac_expired(nac_expired), .frame_timeout(frame_timeout),
    .chk_req(chk_req), .chk_valid(chk_valid), .chk_bounds_ok(chk_bounds_ok),
    .chk_prot_ok(chk_prot_ok), .chk_mode_ok(chk_mode_ok), .run_req(run_req),
    .run_done(run_done), .run_ok(run_ok), .run_is_read(run_is_read),
    .run_is_jump(run_is_jump), .cmd_len(cmd_len), .rd_addr(rd_addr),
    .rd_data(rd_data), .resp_req(resp_req), .resp_is_data(resp_is_data),
    .resp_err(resp_err), .resp_done(resp_done));
  bllfe_host i_bllfe_host (.clk(clk), .rx_ready(rx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end));

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      error_cnt++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic settle(input string name);
    for (int k = 0; k < 3000 && notes.size() != 0; k++) @(posedge clk);
    repeat (8) @(posedge clk);
    check("pending commands", 0, notes.size());
    $display("test %s done", name);
  endtask
  task automatic frame(input logic [7:0] nad, input logic [7:0] typ,
                       input int n, input int mode);
    logic [7:0] f[$];
    f = {nad, typ};
    repeat (n - 2) f.push_back(8'($urandom));
    i_bllfe_host.send(f, mode);
  endtask
  task automatic pass(input logic [7:0] nad, input bit two, input int mode);
    logic [7:0]  f[$];
    logic [47:0] p;
    p = two ? bllfe_pkg::PASS2_PAT : bllfe_pkg::PASS1_PAT;
    f = {nad};
    for (int i = 5; i >= 0; i--) f.push_back(p[i*8 +: 8]);
    i_bllfe_host.send(f, mode);
  endtask
  task automatic cmd(input logic [7:0] nad, input logic [7:0] typ,
                     input int n, input logic cok, input logic rok);
    notes.push_back('{8'(n), typ, cok, rok, typ == 8'h84, typ == 8'h83});
    frame(nad, typ, n, 0);
  endtask

  // ----------------------------------------------------------
  // Memory back end and result watcher
  // ----------------------------------------------------------
  initial begin
    bllfe_note_t n;
    logic        resp;
    forever begin
      @(posedge clk);
      #1;
      if (resp_req === 1'b1) check("stray resp_req", 0, 1);
      if (chk_req === 1'b1 && notes.size() == 0) begin
        check("stray chk_req", 0, 1);
      end else if (chk_req === 1'b1) begin
        n = notes[0];
        if (n.len != 0) check("cmd_len", n.len, cmd_len);
        rd_addr = 8'h01;
        chk_valid = 1'b1;
        {chk_bounds_ok, chk_prot_ok, chk_mode_ok} =
          n.cok ? 3'h7 : 3'h7 ^ (3'h1 << $urandom_range(2));
        @(posedge clk);
        #1;
        chk_valid = 1'b0;
        check("rd_data", n.typ, rd_data);
        if (n.cok) begin
          check("run_req", 1, run_req);
          repeat ($urandom_range(3)) @(posedge clk);
          #1;
          run_done = 1'b1;
          {run_ok, run_is_read, run_is_jump} = {n.rok, n.rd, n.jmp};
          @(posedge clk);
          #1;
          run_done = 1'b0;
        end
        resp = !(n.cok && n.rok && n.jmp);
        for (int k = 0; k < 4 && resp && resp_req !== 1'b1; k++) begin
          @(posedge clk);
          #1;
        end
        check("resp_req", resp, resp_req);
        if (resp) begin
          check("resp_is_data", n.cok && n.rok && n.rd, resp_is_data);
          check("resp_err", !(n.cok && n.rok), resp_err);
          repeat ($urandom_range(2)) @(posedge clk);
          #1;
          resp_done = 1'b1;
          @(posedge clk);
          #1;
          resp_done = 1'b0;
        end
        void'(notes.pop_front());
      end
    end
  end

  // ----------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #900000;
    error_cnt++;
    summarize();
  end
  initial begin
    logic [7:0] a, b;
    logic [7:0] typs [3];
    int         k;
    typs = '{8'h84, 8'h83, 8'h88};
    {rst, chk_valid, chk_bounds_ok, chk_prot_ok, chk_mode_ok} = 5'h10;
    {run_done, run_ok, run_is_read, run_is_jump, resp_done} = 5'h00;
    {nac_cfg, ift_cfg, rd_addr} = {8'hFF, 8'h38, 8'h00};
    error_cnt = 0;
    total_checks = 0;
    void'($urandom(72940));
    a = 8'($urandom_range(253));
    b = a + 8'h01;
    node_addr = a;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    frame(8'hFF, 8'h84, 4, 0);
    pass(a, 1, 0);
    check("locked after reset", 1, link_locked);
    settle("locked");
    pass(a, 0, 0);
    pass(b, 1, 0);
    pass(a, 0, 1);
    pass(a, 1, 0);
    pass(a, 0, 0);
    frame(a, 8'h84, 3, 0);
    pass(a, 1, 0);
    pass(a, 0, 0);
    pass(a, 1, 1);
    check("still locked", 1, link_locked);
    pass(b, 0, 0);
    pass(a, 0, 0);
    pass(a, 1, 0);
    repeat (4) @(posedge clk);
    #1;
    check("unlocked", 0, link_locked);
    settle("unlock");
    for (int i = 0; i < 15; i++) begin
      cmd(i % 2 ? 8'hFF : a, typs[i % 3], 2 + $urandom_range(5),
          i % 4 != 3, i % 5 != 4);
      frame(b, typs[i % 3], 3, 0);
      settle("single");
    end
    notes.push_back('{8'h89, 8'h05, 1'b1, 1'b1, 1'b0, 1'b0});
    frame(a, 8'h05, 7, 0);
    frame(a, 8'h7F, 130, 0);
    settle("multi");
    frame(a, 8'h05, 7, 0);
    frame(a, 8'h7F, 135, 0);
    frame(a, 8'h7F, 5, 0);
    cmd(a, 8'h84, 5, 1, 1);
    settle("overflow");
    frame(a, 8'h84, 3, 2);
    #1;
    for (k = 0; k < 1300 && frame_timeout !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    check("frame_timeout", 1, frame_timeout);
    check("timeout span", 1, k >= 55 * TICK_T - 20 && k <= 57 * TICK_T);
    cmd(a, 8'h88, 4, 1, 1);
    settle("timeout");
    #1;
    nac_cfg = 8'h02;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3 * TICK_T + 8) @(posedge clk);
    #1;
    check("nac_expired", 1, nac_expired);
    pass(a, 0, 0);
    pass(a, 1, 0);
    check("locked after expiry", 1, link_locked);
    settle("no activity");
    summarize();
  end
endmodule

/* File: src/bllfe_pkg.sv */
// Constants and types of the boot loader link front end
package bllfe_pkg;
  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS     = 1000000;
  localparam int TICK_MS       = 5;
  localparam int TICK_CYC      = TICK_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam logic [7:0] IFT_DEFAULT = 8'h38;
  localparam logic [7:0] NAC_FOREVER = 8'hFF;

  // ----------------------------------------------------------
  // Frame and command layout
  // ----------------------------------------------------------
  localparam logic [7:0] NAD_BROADCAST  = 8'hFF;
  localparam logic [7:0] END_BLOCK_TYPE = 8'h7F;
  localparam int NAD_POS        = 0;
  localparam int TYPE_POS       = 1;
  localparam int TYPE_MSB       = 7;
  localparam int MIN_CMD_FRAME  = 2;
  localparam int HDR_BYTES      = 7;
  localparam int END_DATA_BYTES = 130;
  localparam int MAX_CMD_BYTES  = HDR_BYTES + END_DATA_BYTES;
  localparam int PASS_LEN       = 7;
  localparam int PASS_PAT_BYTES = 6;
  localparam logic [47:0] PASS1_PAT = 48'h4C494E504153;
  localparam logic [47:0] PASS2_PAT = 48'h424F4F544B59;

  // ----------------------------------------------------------
  // States
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    BLLFE_LK_WAIT1,
    BLLFE_LK_WAIT2,
    BLLFE_LK_OPEN
  } bllfe_lock_t;

  typedef enum logic [2:0] {
    BLLFE_S_HDR,
    BLLFE_S_END,
    BLLFE_S_CHECK,
    BLLFE_S_RUN,
    BLLFE_S_RESP
  } bllfe_cmd_t;
endpackage

/* File: src/bllfe_top.sv */
// Boot loader link front end: unlock, collection, dispatch, timeouts
`timescale 1ns/100ps
module bllfe_top #(
  parameter int TICK_CYC  = bllfe_pkg::TICK_CYC,
  parameter int MAX_BYTES = bllfe_pkg::MAX_CMD_BYTES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_end,
  output logic            rx_ready,
  input  wire logic [7:0] nac_cfg,
  input  wire logic [7:0] ift_cfg,
  input  wire logic [7:0] node_addr,
  output logic            link_locked,
  output logic            nac_expired,
  output logic            frame_timeout,
  output logic            chk_req,
  input  wire logic       chk_valid,
  input  wire logic       chk_bounds_ok,
  input  wire logic       chk_prot_ok,
  input  wire logic       chk_mode_ok,
  output logic            run_req,
  input  wire logic       run_done,
  input  wire logic       run_ok,
  input  wire logic       run_is_read,
  input  wire logic       run_is_jump,
  output logic [7:0]      cmd_len,
  input  wire logic [7:0] rd_addr,
  output logic [7:0]      rd_data,
  output logic            resp_req,
  output logic            resp_is_data,
  output logic            resp_err,
  input  wire logic       resp_done
);
  localparam int PRE_W = $clog2(TICK_CYC);

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  logic [8:0]  fb_q [0:1];
  logic [8:0]  fb_d [0:1];
  logic        wp_q, wp_d, rp_q, rp_d;
  logic [1:0]  cnt_q, cnt_d;
  logic        rdy_q, rdy_d;
  logic        push, pop, accept;
  logic [7:0]  hd_data;
  logic        hd_end;

  logic [7:0]  mem_q [0:MAX_BYTES-1];
  logic        we;
  logic [7:0]  widx;
  logic [7:0]  wdat;
  logic [7:0]  pos_q, pos_d, sum_q, sum_d;
  logic        ovf_q, ovf_d, busy_q, busy_d;
  logic        fdone_q, fdone_d, fgood_q, fgood_d, fovf_q, fovf_d;
  logic [7:0]  flen_q, flen_d;
  logic [8:0]  idx;
  logic [8:0]  s9;

  bllfe_pkg::bllfe_lock_t lock_q, lock_d;
  logic [7:0]  nad_q, nad_d;
  logic        lkd_q, lkd_d, nexp_q, nexp_d, to_q, to_d;
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [7:0]  unit_q, unit_d;
  logic        synced, act;
  logic [7:0]  lim;
  logic        p1, p2;

  bllfe_pkg::bllfe_cmd_t st_q, st_d;
  logic [7:0]  base_q, base_d, clen_q, clen_d, rdd_q, rdd_d;
  logic        chk_q, chk_d, run_q, run_d;
  logic        rsp_q, rsp_d, rdat_q, rdat_d, rerr_q, rerr_d;
  logic        addressed;
  logic [7:0]  mtype;
  logic [8:0]  tix;

  // Passphrase pattern check on the stored frame
  function automatic logic pat_ok(input logic [47:0] pat);
    logic r;
    r = 1'b1;
    for (int k = 1; k <= bllfe_pkg::PASS_PAT_BYTES; k++) begin
      if (mem_q[k] != pat[8*(bllfe_pkg::PASS_PAT_BYTES-k) +: 8]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------
  // Two-entry input buffer
  // ----------------------------------------------------------
  assign hd_data = fb_q[rp_q][7:0];
  assign hd_end  = fb_q[rp_q][8];
  assign push    = rx_valid && rdy_q;
  assign accept  = !fdone_q && (st_q == bllfe_pkg::BLLFE_S_HDR ||
                                st_q == bllfe_pkg::BLLFE_S_END);
  assign pop     = (cnt_q != 2'h0) && accept;

  always_comb begin
    fb_d  = fb_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      fb_d[wp_q] = {rx_end, rx_data};
      wp_d       = !wp_q;
    end
    if (pop) begin
      rp_d = !rp_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    rdy_d = cnt_d < 2'h2;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fb_q[0] <= 9'h000;
      fb_q[1] <= 9'h000;
      wp_q    <= 1'b0;
      rp_q    <= 1'b0;
      cnt_q   <= 2'h0;
      rdy_q   <= 1'b0;
    end else begin
      fb_q  <= fb_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  // ----------------------------------------------------------
  // Frame receiver and checksum
  // ----------------------------------------------------------
  always_comb begin
    pos_d   = pos_q;
    sum_d   = sum_q;
    ovf_d   = ovf_q;
    busy_d  = busy_q;
    fdone_d = 1'b0;
    fgood_d = fgood_q;
    fovf_d  = fovf_q;
    flen_d  = flen_q;
    we      = 1'b0;
    idx     = {1'b0, base_q} + {1'b0, pos_q};
    widx    = idx[7:0];
    wdat    = hd_data;
    s9      = {1'b0, sum_q} + {1'b0, hd_data};
    if (to_q) begin
      pos_d  = 8'h00;
      sum_d  = 8'h00;
      ovf_d  = 1'b0;
      busy_d = 1'b0;
      idx    = {1'b0, base_q};
      widx   = idx[7:0];
      s9     = {1'b0, hd_data};
    end
    if (pop) begin
      if (hd_end) begin
        fdone_d = 1'b1;
        fgood_d = (hd_data == ~sum_d);
        fovf_d  = ovf_d;
        flen_d  = pos_d;
        pos_d   = 8'h00;
        sum_d   = 8'h00;
        ovf_d   = 1'b0;
        busy_d  = 1'b0;
      end else begin
        sum_d  = s9[8] ? s9[7:0] + 8'h01 : s9[7:0];
        busy_d = 1'b1;
        if (idx < 9'(MAX_BYTES)) begin
          we = 1'b1;
        end else begin
          ovf_d = 1'b1;
        end
        if (pos_d != 8'hFF) begin
          pos_d = pos_d + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[widx] <= wdat;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_q   <= 8'h00;
      sum_q   <= 8'h00;
      ovf_q   <= 1'b0;
      busy_q  <= 1'b0;
      fdone_q <= 1'b0;
      fgood_q <= 1'b0;
      fovf_q  <= 1'b0;
      flen_q  <= 8'h00;
    end else begin
      pos_q   <= pos_d;
      sum_q   <= sum_d;
      ovf_q   <= ovf_d;
      busy_q  <= busy_d;
      fdone_q <= fdone_d;
      fgood_q <= fgood_d;
      fovf_q  <= fovf_d;
      flen_q  <= flen_d;
    end
  end

  // ----------------------------------------------------------
  // Link lock and timers
  // ----------------------------------------------------------
  assign synced = (lock_q == bllfe_pkg::BLLFE_LK_OPEN);

  always_comb begin
    lock_d = lock_q;
    nad_d  = nad_q;
    nexp_d = nexp_q;
    to_d   = 1'b0;
    pre_d  = pre_q;
    unit_d = unit_q;
    // No-activity before sync, interframe inside frames after
    act = synced ? busy_q
                 : (nac_cfg != bllfe_pkg::NAC_FOREVER) && !nexp_q;
    lim = synced ? ift_cfg : nac_cfg;
    if (!act) begin
      pre_d  = '0;
      unit_d = 8'h00;
    end else if (pre_q == PRE_W'(TICK_CYC - 1)) begin
      pre_d  = '0;
      unit_d = unit_q + 8'h01;
      if ({1'b0, unit_q} + 9'h001 >= {1'b0, lim}) begin
        unit_d = 8'h00;
        if (synced) begin
          to_d = 1'b1;
        end else begin
          nexp_d = 1'b1;
        end
      end
    end else begin
      pre_d = pre_q + PRE_W'(1);
    end
    p1 = fgood_q && flen_q == 8'(bllfe_pkg::PASS_LEN) &&
         pat_ok(bllfe_pkg::PASS1_PAT);
    p2 = fgood_q && flen_q == 8'(bllfe_pkg::PASS_LEN) &&
         pat_ok(bllfe_pkg::PASS2_PAT) &&
         mem_q[bllfe_pkg::NAD_POS] == nad_q;
    // Locked frames are consumed here only, never answered
    if (fdone_q && !synced && !nexp_q) begin
      if (p1) begin
        lock_d = bllfe_pkg::BLLFE_LK_WAIT2;
        nad_d  = mem_q[bllfe_pkg::NAD_POS];
      end else if (lock_q == bllfe_pkg::BLLFE_LK_WAIT2 && p2) begin
        lock_d = bllfe_pkg::BLLFE_LK_OPEN;
      end else begin
        lock_d = bllfe_pkg::BLLFE_LK_WAIT1;
      end
    end
    lkd_d = (lock_d != bllfe_pkg::BLLFE_LK_OPEN);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_q <= bllfe_pkg::BLLFE_LK_WAIT1;
      nad_q  <= 8'h00;
      lkd_q  <= 1'b1;
      nexp_q <= 1'b0;
      to_q   <= 1'b0;
      pre_q  <= '0;
      unit_q <= 8'h00;
    end else begin
      lock_q <= lock_d;
      nad_q  <= nad_d;
      lkd_q  <= lkd_d;
      nexp_q <= nexp_d;
      to_q   <= to_d;
      pre_q  <= pre_d;
      unit_q <= unit_d;
    end
  end

  // ----------------------------------------------------------
  // Command collection and dispatch
  // ----------------------------------------------------------
  // Address and type of the message that starts at base_q
  assign tix       = {1'b0, base_q} + 9'(bllfe_pkg::TYPE_POS);
  assign mtype     = (tix < 9'(MAX_BYTES)) ? mem_q[tix[7:0]] : 8'h00;
  assign addressed = (base_q < 8'(MAX_BYTES)) &&
                     (mem_q[base_q] == node_addr ||
                      mem_q[base_q] == bllfe_pkg::NAD_BROADCAST);

  always_comb begin
    st_d   = st_q;
    base_d = base_q;
    clen_d = clen_q;
    chk_d  = 1'b0;
    run_d  = 1'b0;
    rsp_d  = 1'b0;
    rdat_d = rdat_q;
    rerr_d = rerr_q;
    rdd_d  = (rd_addr < 8'(MAX_BYTES)) ? mem_q[rd_addr] : 8'h00;
    case (st_q)
      bllfe_pkg::BLLFE_S_HDR: begin
        if (fdone_q && synced && fgood_q && addressed) begin
          if (flen_q < 8'(bllfe_pkg::MIN_CMD_FRAME) ||
              mtype == bllfe_pkg::END_BLOCK_TYPE) begin
            st_d = bllfe_pkg::BLLFE_S_HDR;
          end else if (mtype[bllfe_pkg::TYPE_MSB]) begin
            clen_d = flen_q;
            chk_d  = 1'b1;
            st_d   = bllfe_pkg::BLLFE_S_CHECK;
          end else begin
            base_d = flen_q;
            st_d   = bllfe_pkg::BLLFE_S_END;
          end
        end
      end
      bllfe_pkg::BLLFE_S_END: begin
        if (fdone_q && fgood_q && addressed) begin
          if (flen_q >= 8'(bllfe_pkg::MIN_CMD_FRAME) &&
              mtype == bllfe_pkg::END_BLOCK_TYPE && !fovf_q) begin
            clen_d = base_q + flen_q;
            chk_d  = 1'b1;
            st_d   = bllfe_pkg::BLLFE_S_CHECK;
          end else begin
            base_d = 8'h00;
            st_d   = bllfe_pkg::BLLFE_S_HDR;
          end
        end
      end
      bllfe_pkg::BLLFE_S_CHECK: begin
        if (chk_valid) begin
          if (chk_bounds_ok && chk_prot_ok && chk_mode_ok) begin
            run_d = 1'b1;
            st_d  = bllfe_pkg::BLLFE_S_RUN;
          end else begin
            rsp_d  = 1'b1;
            rdat_d = 1'b0;
            rerr_d = 1'b1;
            st_d   = bllfe_pkg::BLLFE_S_RESP;
          end
        end
      end
      bllfe_pkg::BLLFE_S_RUN: begin
        if (run_done) begin
          if (run_ok && run_is_jump) begin
            base_d = 8'h00;
            st_d   = bllfe_pkg::BLLFE_S_HDR;
          end else begin
            rsp_d  = 1'b1;
            rdat_d = run_ok && run_is_read;
            rerr_d = !run_ok;
            st_d   = bllfe_pkg::BLLFE_S_RESP;
          end
        end
      end
      bllfe_pkg::BLLFE_S_RESP: begin
        if (resp_done) begin
          base_d = 8'h00;
          st_d   = bllfe_pkg::BLLFE_S_HDR;
        end
      end
      default: begin
        base_d = 8'h00;
        st_d   = bllfe_pkg::BLLFE_S_HDR;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q   <= bllfe_pkg::BLLFE_S_HDR;
      base_q <= 8'h00;
      clen_q <= 8'h00;
      chk_q  <= 1'b0;
      run_q  <= 1'b0;
      rsp_q  <= 1'b0;
      rdat_q <= 1'b0;
      rerr_q <= 1'b0;
      rdd_q  <= 8'h00;
    end else begin
      st_q   <= st_d;
      base_q <= base_d;
      clen_q <= clen_d;
      chk_q  <= chk_d;
      run_q  <= run_d;
      rsp_q  <= rsp_d;
      rdat_q <= rdat_d;
      rerr_q <= rerr_d;
      rdd_q  <= rdd_d;
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign rx_ready      = rdy_q;
  assign link_locked   = lkd_q;
  assign nac_expired   = nexp_q;
  assign frame_timeout = to_q;
  assign chk_req       = chk_q;
  assign run_req       = run_q;
  assign cmd_len       = clen_q;
  assign rd_data       = rdd_q;
  assign resp_req      = rsp_q;
  assign resp_is_data  = rdat_q;
  assign resp_err      = rerr_q;
endmodule
